// ===== hw/cip_consts.svh
`ifndef CIP_CONSTS_SVH
`define CIP_CONSTS_SVH

`define CIP_PIX_W        10
`define CIP_ADDR_CTRL    8'h00
`define CIP_ADDR_CMD     8'h04
`define CIP_ADDR_ROI_COL 8'h08
`define CIP_ADDR_ROI_ROW 8'h0c
`define CIP_ADDR_DELAY   8'h10
`define CIP_ADDR_SUMCNT  8'h14
`define CIP_ADDR_STATUS  8'h18
`define CIP_ADDR_TABADR  8'h1c
`define CIP_ADDR_OFFSET  8'h20
`define CIP_ADDR_GAIN    8'h24
`define CIP_ADDR_LUT     8'h28

`define CIP_F_MODE  1:0
`define CIP_F_PIX8  2
`define CIP_F_OUT8  3
`define CIP_F_LUTEN 4
`define CIP_F_CC1   9:8
`define CIP_F_CC2   11:10
`define CIP_F_CC3   13:12
`define CIP_F_CMD1  0
`define CIP_F_CMD2  1
`define CIP_F_CMD3  2
`define CIP_F_START 10:0
`define CIP_F_SIZE  26:16
`define CIP_F_CNT   15:0

`define CIP_RST_CTRL   32'h0000_0000
`define CIP_RST_ROI    32'h0008_0000
`define CIP_RST_DELAY  32'h0000_0000
`define CIP_RST_SUMCNT 32'h0000_0001
`define CIP_GAIN_ONE   8'h80
`define CIP_GAIN_SHIFT 7
`define CIP_FS8        10'h0ff
`define CIP_FS10       10'h3ff
`define CIP_LINE_GAP   2'h2
`define CIP_BYTE_LAST  2'h3
`endif

// ===== hw/cip_pkg.sv
`include "cip_consts.svh"
package cip_pkg;
  typedef enum logic [1:0] {MEM_DIRECT = 2'b00, MEM_FIFO = 2'b01, MEM_CIRC = 2'b10, MEM_SUM = 2'b11} cip_mode_t;
  typedef enum logic [1:0] {CC_LINK = 2'b00, CC_SERIAL = 2'b01, CC_ON = 2'b10, CC_OFF = 2'b11} cip_ccsrc_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_LINE = 2'b01, RD_GAP = 2'b10} cip_rdst_t;
  typedef struct packed {
    logic                  fval;
    logic                  lval;
    logic                  dval;
    logic [`CIP_PIX_W-1:0] data;
  } cip_pix_t;
endpackage

// ===== hw/cip_pipeline.sv
`timescale 1ns/1ps
`default_nettype none
`include "cip_consts.svh"
module cip_pipeline #(
  parameter int NUM_BUF   = 4,
  parameter int IMG_PIX   = 64,
  parameter int LUT_DEPTH = 1024
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       regAddr,
  input  wire logic [31:0]      regWrData,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [31:0]           regRdData,
  input  wire cip_pkg::cip_pix_t sensorIn,
  input  wire logic             linkCc1,
  input  wire logic             linkCc2,
  input  wire logic             linkCc3,
  output cip_pkg::cip_pix_t     pixOut,
  output logic                  trigOut
);
  localparam int BW = $clog2(NUM_BUF);
  localparam int IW = $clog2(IMG_PIX);
  localparam int AW = $clog2(NUM_BUF * IMG_PIX);
  localparam int PW = `CIP_PIX_W;
  localparam int LW = $clog2(LUT_DEPTH);

  // ***************************************************
  // Register file
  // ***************************************************
  logic [31:0]   ctrl_r, roiCol_r, roiRow_r, delay_r, sumCnt_r, tabAdr_r, regRdData_r;
  logic [2:0]    cmd_r;
  logic [PW-1:0] offTab [IMG_PIX];
  logic [7:0]    gainTab [IMG_PIX];
  logic [PW-1:0] lutTab [LUT_DEPTH];
  logic [BW:0]   count_r;
  logic [7:0]    pendReq_r;
  logic          stopped_r, triggered_r;
  cip_pkg::cip_rdst_t rdState_r;

  cip_pkg::cip_mode_t mode;
  assign mode = cip_pkg::cip_mode_t'(ctrl_r[`CIP_F_MODE]);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r   <= `CIP_RST_CTRL;
      roiCol_r <= `CIP_RST_ROI;
      roiRow_r <= `CIP_RST_ROI;
      delay_r  <= `CIP_RST_DELAY;
      sumCnt_r <= `CIP_RST_SUMCNT;
      tabAdr_r <= 32'h0;
    end
    else if (regWr)
    begin
      case (regAddr)
        `CIP_ADDR_CTRL:    ctrl_r <= regWrData;
        `CIP_ADDR_ROI_COL: roiCol_r <= regWrData;
        `CIP_ADDR_ROI_ROW: roiRow_r <= regWrData;
        `CIP_ADDR_DELAY:   delay_r <= regWrData;
        `CIP_ADDR_SUMCNT:  sumCnt_r <= regWrData;
        `CIP_ADDR_TABADR:  tabAdr_r <= regWrData;
        default:           ;
      endcase
    end
  end

  // Serial commands are one-cycle pulses
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cmd_r <= 3'h0;
    else if (regWr && regAddr == `CIP_ADDR_CMD)
      cmd_r <= regWrData[2:0];
    else
      cmd_r <= 3'h0;
  end

  // Tables reset to unity gain, zero offset, identity map
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < IMG_PIX; i++)
      begin
        offTab[i]  <= '0;
        gainTab[i] <= `CIP_GAIN_ONE;
      end
      for (int i = 0; i < LUT_DEPTH; i++)
        lutTab[i] <= PW'(i);
    end
    else if (regWr)
    begin
      if (regAddr == `CIP_ADDR_OFFSET && tabAdr_r < 32'(IMG_PIX))
        offTab[IW'(tabAdr_r)] <= regWrData[PW-1:0];
      if (regAddr == `CIP_ADDR_GAIN && tabAdr_r < 32'(IMG_PIX))
        gainTab[IW'(tabAdr_r)] <= regWrData[7:0];
      if (regAddr == `CIP_ADDR_LUT && tabAdr_r < 32'(LUT_DEPTH))
        lutTab[LW'(tabAdr_r)] <= regWrData[PW-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData_r <= 32'h0;
    else if (regRd)
    begin
      case (regAddr)
        `CIP_ADDR_CTRL:    regRdData_r <= ctrl_r;
        `CIP_ADDR_ROI_COL: regRdData_r <= roiCol_r;
        `CIP_ADDR_ROI_ROW: regRdData_r <= roiRow_r;
        `CIP_ADDR_DELAY:   regRdData_r <= delay_r;
        `CIP_ADDR_SUMCNT:  regRdData_r <= sumCnt_r;
        `CIP_ADDR_TABADR:  regRdData_r <= tabAdr_r;
        `CIP_ADDR_STATUS:  regRdData_r <= {16'h0, pendReq_r, 1'b0, rdState_r, stopped_r, triggered_r, 3'(count_r)};
        default:           regRdData_r <= 32'h0;
      endcase
    end
    else
      regRdData_r <= 32'h0;
  end
  assign regRdData = regRdData_r;

  // ***************************************************
  // Camera control sources
  // ***************************************************
  function automatic logic ccLevel(input logic [1:0] src, input logic link, input logic ser);
    case (cip_pkg::cip_ccsrc_t'(src))
      cip_pkg::CC_LINK:   ccLevel = link;
      cip_pkg::CC_SERIAL: ccLevel = ser;
      cip_pkg::CC_ON:     ccLevel = 1'b1;
      default:            ccLevel = 1'b0;
    endcase
  endfunction

  logic cc2Lvl, cc3Lvl, cc2Prev_r, cc3Prev_r, cc2Ev, cc3Ev;
  assign cc2Lvl = ccLevel(ctrl_r[`CIP_F_CC2], linkCc2, cmd_r[`CIP_F_CMD2]);
  assign cc3Lvl = ccLevel(ctrl_r[`CIP_F_CC3], linkCc3, cmd_r[`CIP_F_CMD3]);
  assign trigOut = ccLevel(ctrl_r[`CIP_F_CC1], linkCc1, cmd_r[`CIP_F_CMD1]);
  // Always-on acts as a request every cycle, not a single edge
  assign cc2Ev = (ctrl_r[`CIP_F_CC2] == cip_pkg::CC_ON) ? 1'b1 : cc2Lvl & ~cc2Prev_r;
  assign cc3Ev = (ctrl_r[`CIP_F_CC3] == cip_pkg::CC_ON) ? 1'b1 : cc3Lvl & ~cc3Prev_r;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cc2Prev_r <= 1'b0;
      cc3Prev_r <= 1'b0;
    end
    else
    begin
      cc2Prev_r <= cc2Lvl;
      cc3Prev_r <= cc3Lvl;
    end
  end

  // ***************************************************
  // Region of interest and correction
  // ***************************************************
  function automatic logic inSpan(input logic [10:0] v, input logic [31:0] r);
    inSpan = ({1'b0, v} >= {1'b0, r[`CIP_F_START]}) && ({1'b0, v} < {1'b0, r[`CIP_F_START]} + {1'b0, r[`CIP_F_SIZE]});
  endfunction

  logic [10:0]   col_r, row_r;
  logic [IW:0]   roiIdx_r;
  logic          lvalPrev_r, inRoi, pixIn;
  logic          s1Valid_r, s1Fval_r, s1Lval_r, corrValid_r, corrFval_r, corrLval_r, fvalPrev_r;
  logic [PW-1:0] s1Pix_r, corrPix_r, diff, fullScale;
  logic [IW-1:0] s1Idx_r, corrIdx_r;
  logic [17:0]   prod;
  logic [10:0]   scaled;

  assign pixIn = sensorIn.fval & sensorIn.lval & sensorIn.dval;
  assign inRoi = inSpan(col_r, roiCol_r) && inSpan(row_r, roiRow_r);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      col_r      <= '0;
      row_r      <= '0;
      roiIdx_r   <= '0;
      lvalPrev_r <= 1'b0;
    end
    else
    begin
      lvalPrev_r <= sensorIn.lval;
      if (!sensorIn.fval)
      begin
        col_r    <= '0;
        row_r    <= '0;
        roiIdx_r <= '0;
      end
      else
      begin
        if (pixIn)
          col_r <= col_r + 11'h1;
        else if (lvalPrev_r && !sensorIn.lval)
        begin
          col_r <= '0;
          row_r <= row_r + 11'h1;
        end
        if (pixIn && inRoi && roiIdx_r < (IW + 1)'(IMG_PIX))
          roiIdx_r <= roiIdx_r + 1'b1;
      end
    end
  end

  assign diff = (s1Pix_r > offTab[s1Idx_r]) ? s1Pix_r - offTab[s1Idx_r] : '0;
  assign prod = 18'(diff) * 18'(gainTab[s1Idx_r]);
  assign scaled = prod[`CIP_GAIN_SHIFT +: 11];
  assign fullScale = ctrl_r[`CIP_F_PIX8] ? `CIP_FS8 : `CIP_FS10;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1Valid_r <= 1'b0;
      s1Fval_r <= 1'b0;
      s1Lval_r <= 1'b0;
      s1Pix_r <= '0;
      s1Idx_r <= '0;
      corrValid_r <= 1'b0;
      corrFval_r <= 1'b0;
      corrLval_r <= 1'b0;
      corrPix_r <= '0;
      corrIdx_r <= '0;
      fvalPrev_r <= 1'b0;
    end
    else
    begin
      s1Valid_r   <= pixIn && inRoi && roiIdx_r < (IW + 1)'(IMG_PIX);
      s1Fval_r    <= sensorIn.fval;
      s1Lval_r    <= sensorIn.lval;
      s1Pix_r     <= sensorIn.data;
      s1Idx_r     <= roiIdx_r[IW-1:0];
      corrValid_r <= s1Valid_r;
      corrFval_r  <= s1Fval_r;
      corrLval_r  <= s1Lval_r;
      corrIdx_r   <= s1Idx_r;
      fvalPrev_r  <= corrFval_r;
      corrPix_r   <= ({1'b0, fullScale} <= scaled) ? fullScale : scaled[PW-1:0];
    end
  end

  // ***************************************************
  // Frame memory control
  // ***************************************************
  function automatic logic [AW-1:0] memAddr(input logic [BW-1:0] b, input logic [IW-1:0] i);
    memAddr = AW'({b, i});
  endfunction

  logic [31:0]   mem [NUM_BUF * IMG_PIX];
  logic [BW-1:0] wp_r, rp_r;
  logic [15:0]   delayCnt_r, frmCnt_r;
  logic          wrActive_r, frameStart, frameEnd, accept, startRead, readDone, memOn, full, sumDone;
  logic          circRoom;

  assign memOn = mode != cip_pkg::MEM_DIRECT;
  assign frameStart = corrFval_r & ~fvalPrev_r;
  assign frameEnd = ~corrFval_r & fvalPrev_r;
  assign full = count_r == (BW + 1)'(NUM_BUF);
  // free-running circular overwrites oldest; stopped and full refuses
  assign circRoom = !stopped_r || !full;
  // FIFO stops when full; summing halts when full
  assign accept = frameStart && memOn && (mode == cip_pkg::MEM_CIRC ? circRoom : !full);
  assign sumDone = frmCnt_r + 16'h1 >= sumCnt_r[`CIP_F_CNT];
  // request served once an image is held, and in circular mode only once stopped
  assign startRead = rdState_r == cip_pkg::RD_IDLE && memOn && pendReq_r != 8'h0 && count_r != '0
                     && (mode != cip_pkg::MEM_CIRC || stopped_r) && !cc3Ev;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      wrActive_r <= 1'b0;
    else if (cc3Ev || frameEnd)
      wrActive_r <= 1'b0;
    else if (accept)
      wrActive_r <= 1'b1;
  end

  logic endWrite, wrAdv, dropOld;
  assign endWrite = frameEnd && wrActive_r && !cc3Ev;
  assign wrAdv = endWrite && (mode != cip_pkg::MEM_SUM || sumDone);
  assign dropOld = wrAdv && mode == cip_pkg::MEM_CIRC && !stopped_r && full;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      count_r <= '0;
      frmCnt_r <= '0;
    end
    else if (cc3Ev)
    begin
      wp_r <= '0;
      rp_r <= '0;
      count_r <= '0;
      frmCnt_r <= '0;
    end
    else
    begin
      if (wrAdv)
        wp_r <= wp_r + 1'b1;
      if (readDone || dropOld)
        rp_r <= rp_r + 1'b1;
      if (wrAdv && !dropOld && !readDone)
        count_r <= count_r + 1'b1;
      else if (readDone && !wrAdv)
        count_r <= count_r - 1'b1;
      if (endWrite && mode == cip_pkg::MEM_SUM)
        frmCnt_r <= sumDone ? 16'h0 : frmCnt_r + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      triggered_r <= 1'b0;
      stopped_r <= 1'b0;
      delayCnt_r <= '0;
    end
    else if (cc3Ev)
    begin
      triggered_r <= 1'b0;
      stopped_r <= 1'b0;
      delayCnt_r <= '0;
    end
    else if (mode == cip_pkg::MEM_CIRC)
    begin
      if (cc2Ev && !triggered_r)
        triggered_r <= 1'b1;
      if (triggered_r && !stopped_r)
      begin
        if (delayCnt_r >= delay_r[`CIP_F_CNT])
          stopped_r <= 1'b1;
        else if (endWrite)
          delayCnt_r <= delayCnt_r + 16'h1;
      end
    end
  end

  // Pending requests; a new request in the cycle one is consumed leaves the count unchanged
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pendReq_r <= 8'h0;
    else if (cc3Ev)
      pendReq_r <= 8'h0;
    else if (cc2Ev && !startRead && memOn && pendReq_r != 8'hff)
      pendReq_r <= pendReq_r + 8'h1;
    else if (startRead && !cc2Ev)
      pendReq_r <= pendReq_r - 8'h1;
  end

  // ***************************************************
  // Readout sequencer
  // ***************************************************
  logic [10:0]   rdCol_r, rdRow_r;
  logic [IW-1:0] rdIdx_r;
  logic [1:0]    rdByte_r, gapCnt_r;
  logic          lastLine_r, lastByte, lineEnd, rdEmit;
  logic [31:0]   rdWord;

  assign rdEmit = rdState_r == cip_pkg::RD_LINE;
  assign rdWord = mem[memAddr(rp_r, rdIdx_r)];
  assign lastByte = mode != cip_pkg::MEM_SUM || rdByte_r == `CIP_BYTE_LAST;
  assign lineEnd = rdEmit && lastByte && rdCol_r + 11'h1 >= roiCol_r[`CIP_F_SIZE];
  assign readDone = lineEnd && rdRow_r + 11'h1 >= roiRow_r[`CIP_F_SIZE];

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdState_r <= cip_pkg::RD_IDLE;
      rdCol_r <= '0;
      rdRow_r <= '0;
      rdIdx_r <= '0;
      rdByte_r <= '0;
      gapCnt_r <= '0;
      lastLine_r <= 1'b0;
    end
    else
    begin
      case (rdState_r)
        cip_pkg::RD_IDLE:
        begin
          rdCol_r <= '0;
          rdRow_r <= '0;
          rdIdx_r <= '0;
          rdByte_r <= '0;
          lastLine_r <= 1'b0;
          if (startRead)
            rdState_r <= cip_pkg::RD_LINE;
        end
        cip_pkg::RD_LINE:
        begin
          rdByte_r <= lastByte ? 2'h0 : rdByte_r + 2'h1;
          if (lastByte)
          begin
            rdCol_r <= rdCol_r + 11'h1;
            if (rdIdx_r != IW'(IMG_PIX - 1))
              rdIdx_r <= rdIdx_r + 1'b1;
          end
          if (lineEnd)
          begin
            rdState_r <= cip_pkg::RD_GAP;
            gapCnt_r <= '0;
            lastLine_r <= readDone;
          end
        end
        cip_pkg::RD_GAP:
        begin
          gapCnt_r <= gapCnt_r + 2'h1;
          if (gapCnt_r + 2'h1 >= `CIP_LINE_GAP)
          begin
            rdCol_r <= '0;
            rdRow_r <= rdRow_r + 11'h1;
            rdState_r <= lastLine_r ? cip_pkg::RD_IDLE : cip_pkg::RD_LINE;
          end
        end
        default: rdState_r <= cip_pkg::RD_IDLE;
      endcase
    end
  end

  // Summing reads then clears; one process owns the array
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_BUF * IMG_PIX; i++)
        mem[i] <= 32'h0;
    end
    else
    begin
      // only region pixels stored
      // First pixel may arrive in the accept cycle itself
      if ((wrActive_r || accept) && corrValid_r)
      begin
        if (mode == cip_pkg::MEM_SUM && frmCnt_r != 16'h0)
          mem[memAddr(wp_r, corrIdx_r)] <= mem[memAddr(wp_r, corrIdx_r)] + 32'(corrPix_r);
        else
          mem[memAddr(wp_r, corrIdx_r)] <= 32'(corrPix_r);
      end
      if (rdEmit && lastByte && mode == cip_pkg::MEM_SUM)
        mem[memAddr(rp_r, rdIdx_r)] <= 32'h0;
    end
  end

  // ***************************************************
  // Lookup table and format funnel
  // ***************************************************
  logic [PW-1:0] srcPix, mapped, outData;
  cip_pkg::cip_pix_t pixOut_r;

  assign srcPix = memOn ? rdWord[PW-1:0] : corrPix_r;
  assign mapped = ctrl_r[`CIP_F_LUTEN] ? lutTab[srcPix] : srcPix;
  always_comb
  begin
    if (memOn && mode == cip_pkg::MEM_SUM)
      outData = PW'(rdWord[{rdByte_r, 3'b000} +: 8]);
    else if (ctrl_r[`CIP_F_OUT8])
      outData = PW'(mapped[PW-1:2]);
    else
      outData = mapped;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pixOut_r <= '0;
    else if (memOn)
    begin
      pixOut_r.fval <= rdEmit || (rdState_r == cip_pkg::RD_GAP && !lastLine_r);
      pixOut_r.lval <= rdEmit;
      pixOut_r.dval <= rdEmit;
      pixOut_r.data <= outData;
    end
    else
    begin
      pixOut_r.fval <= corrFval_r;
      pixOut_r.lval <= corrLval_r;
      pixOut_r.dval <= corrValid_r & corrLval_r & corrFval_r;
      pixOut_r.data <= outData;
    end
  end
  assign pixOut = pixOut_r;

  // ***************************************************
  // Checks
  // ***************************************************
  sequence seqReadStart;
    startRead ##1 rdState_r == cip_pkg::RD_LINE;
  endsequence
  sequence seqSumByte0;
    rdEmit && mode == cip_pkg::MEM_SUM && rdByte_r == 2'h0;
  endsequence

  AST_CLIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s1Valid_r && s1Pix_r <= offTab[s1Idx_r] |=> corrPix_r == '0) else $error("negative not clipped");
  AST_SAT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s1Valid_r && scaled >= {1'b0, fullScale} |=> corrPix_r == $past(fullScale)) else $error("no saturation");
  AST_GAIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s1Valid_r && scaled < {1'b0, fullScale} |=> corrPix_r == $past(prod[17:7], 1)) else $error("gain wrong");
  AST_ROI: assert property (@(posedge ref_clk) disable iff (!reset_n)
    corrValid_r |-> $past(pixIn && inRoi, 2)) else $error("pixel outside region");
  AST_FIFO_FULL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frameStart && mode == cip_pkg::MEM_FIFO && full && !wrActive_r |=> !wrActive_r) else $error("full fifo stored");
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cc3Ev |=> count_r == '0 && pendReq_r == 8'h0 && !stopped_r) else $error("clear ignored");
  AST_CIRC_STOP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(stopped_r) |-> triggered_r && $past(delayCnt_r) >= $past(delay_r[`CIP_F_CNT])) else $error("early stop");
  AST_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seqReadStart |=> pixOut.fval && pixOut.lval && pixOut.dval) else $error("read not started");
  AST_LSB: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seqSumByte0 |=> pixOut.data == PW'($past(rdWord[7:0]))) else $error("byte order");
  AST_DVAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pixOut.dval |-> pixOut.lval && pixOut.fval) else $error("data valid outside window");
endmodule
`default_nettype wire

// ===== verification/cip_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Frame grabber on the output link
// ****************************************
module cip_host_model (
  input  wire logic              ref_clk,
  input  wire cip_pkg::cip_pix_t pixOut,
  output logic                   cc2,
  output logic                   cc3
);
  logic [9:0] got[$];
  initial
  begin
    cc2 = 1'b0;
    cc3 = 1'b0;
  end
  task automatic request();
    @(posedge ref_clk);
    cc2 <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cc2 <= 1'b0;
  endtask
  task automatic clear();
    @(posedge ref_clk);
    cc3 <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cc3 <= 1'b0;
  endtask
  always @(posedge ref_clk)
  begin
    if (pixOut.fval && pixOut.lval && pixOut.dval)
      got.push_back(pixOut.data);
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [7:0]        regAddr = 8'h00;
  logic [31:0]       regWrData = 32'h0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [31:0]       regRdData;
  cip_pkg::cip_pix_t sensorIn = '0;
  cip_pkg::cip_pix_t pixOut;
  logic              linkCc1 = 1'b0;
  logic              linkCc2;
  logic              linkCc3;
  logic              trigOut;
  logic [15:0]       seed = 16'h0049;
  int                bad_count = 0;
  int                n_tests = 0;
  int                gainT[8];
  int                offT[8];
  int                expQ[$];
  int                sumT[8];
  int                fs = 1023;
  int                lutV = 0;
  logic              lutOn = 1'b0;
  logic              out8 = 1'b0;

  cip_pipeline u_cip_pipeline (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sensorIn(sensorIn),
    .linkCc1(linkCc1), .linkCc2(linkCc2), .linkCc3(linkCc3), .pixOut(pixOut), .trigOut(trigOut));
  cip_host_model u_host (.ref_clk(ref_clk), .pixOut(pixOut), .cc2(linkCc2), .cc3(linkCc3));

  always #50 ref_clk = ~ref_clk;

  // ****************************************
  // Helpers and reference model
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Integer model of offset, clip, gain, saturate
  function automatic int corr(input int p, input int i);
    int d;
    d = p - offT[i];
    if (d < 0)
      d = 0;
    d = (d * gainT[i]) >> 7;
    d = (d > fs) ? fs : d;
    // Only table entry 255 is rewritten, the rest stay identity
    if (lutOn && d == 255)
      d = lutV;
    return out8 ? d >> 2 : d;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // Second line lies outside the one-row region, so it must vanish
  task automatic sendFrame();
    @(posedge ref_clk);
    sensorIn <= '{1'b1, 1'b0, 1'b0, 10'h000};
    for (int l = 0; l < 2; l++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        @(posedge ref_clk);
        seed = lfsr(seed);
        sensorIn <= '{1'b1, 1'b1, 1'b1, seed[9:0]};
        if (l == 0)
          expQ.push_back(corr(int'(seed[9:0]), i));
      end
      @(posedge ref_clk);
      sensorIn <= '{1'b1, 1'b0, 1'b0, 10'h000};
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    sensorIn <= '0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic drain();
    int e;
    repeat (40 + 2 * expQ.size()) @(posedge ref_clk);
    while (expQ.size() > 0)
    begin
      e = expQ.pop_front();
      chk((u_host.got.size() > 0) ? 32'(u_host.got.pop_front()) : 32'hffff_ffff, 32'(e));
    end
    chk(32'(u_host.got.size()), 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h0c, 32'h0001_0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h1c, 32'(i));
      seed = lfsr(seed);
      gainT[i] = int'(seed[7:0]);
      wr(8'h24, 32'(gainT[i]));
      seed = lfsr(seed);
      offT[i] = int'(seed[7:0]);
      wr(8'h20, 32'(offT[i]));
    end
    rd(8'h24, 32'h0);
    sendFrame();
    drain();
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    sendFrame();
    repeat (20) @(posedge ref_clk);
    chk(32'(u_host.got.size()), 32'h0);
    u_host.request();
    drain();
    u_host.request();
    sendFrame();
    drain();
    @(posedge ref_clk);
    linkCc1 <= 1'b1;
    #1 chk(32'(trigOut), 32'h1);
    wr(8'h00, 32'h301);
    #1 chk(32'(trigOut), 32'h0);
    repeat (5) sendFrame();
    expQ.delete();
    rd(8'h18, 32'h4);
    u_host.clear();
    rd(8'h18, 32'h0);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1002);
    repeat (5) sendFrame();
    repeat (8) void'(expQ.pop_front());
    u_host.request();
    sendFrame();
    repeat (8) void'(expQ.pop_front());
    repeat (3) u_host.request();
    drain();
    repeat (5) sendFrame();
    repeat (8) void'(expQ.pop_back());
    repeat (4) u_host.request();
    drain();
    wr(8'h04, 32'h4);
    rd(8'h18, 32'h0);
    wr(8'h1c, 32'hff);
    seed = lfsr(seed);
    lutV = int'(seed[9:0]);
    wr(8'h28, 32'(lutV));
    wr(8'h00, 32'h1c);
    fs = 255;
    lutOn = 1'b1;
    out8 = 1'b1;
    sendFrame();
    drain();
    fs = 1023;
    lutOn = 1'b0;
    out8 = 1'b0;
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h403);
    wr(8'h04, 32'h2);
    repeat (2) sendFrame();
    for (int i = 0; i < 8; i++)
      sumT[i] = expQ[i] + expQ[i + 8];
    expQ.delete();
    // Totals leave as four bytes, low byte first
    for (int i = 0; i < 32; i++)
      expQ.push_back((sumT[i / 4] >> (8 * (i % 4))) & 8'hff);
    drain();
    conclude();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
